/* level_sync.sv */
// Two-stage level synchroniser, one bit per lane.
// Assumes each lane is a slow level relative to the receiving clock.
`timescale 1ns/1ns
module level_sync
   import pot_eeprom_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_en,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_en) begin
         meta <= i_d;
         o_q <= meta;
      end
   end

endmodule

/* pot_eeprom_pkg.sv */
// Constants and types shared by the dual potentiometer / EEPROM two-wire slave.
// Assumes a 20 MHz core clock; the serial side runs on the bus clock itself.
package pot_eeprom_pkg;

   // Slave address byte layout
   localparam logic [3:0] DEV_TYPE = 4'ha;
   localparam int ADDR_TYPE_LSB = 4;
   localparam int ADDR_STRAP_BIT = 3;
   localparam int ADDR_SEL_LSB = 1;
   localparam int ADDR_RW_BIT = 0;
   localparam logic [1:0] SEL_EEPROM = 2'b00;
   localparam logic [1:0] SEL_POT = 2'b11;

   // Instruction byte layout
   localparam int INSTR_WT_BIT = 7;
   localparam logic [1:0] POT_CODE_100 = 2'b01;
   localparam logic [1:0] POT_CODE_256 = 2'b10;

   // Highest codes of the two wipers
   localparam logic [7:0] POT100_MAX = 8'h63;
   localparam logic [7:0] POT256_MAX = 8'hff;

   // Reset values
   localparam logic [7:0] NV_WIPER_RESET = 8'h00;
   localparam logic [7:0] EE_ERASED = 8'hff;

   // Protected region bases
   localparam logic [1:0] PROT_NONE = 2'b00;
   localparam logic [1:0] PROT_QUARTER = 2'b01;
   localparam logic [1:0] PROT_HALF = 2'b10;
   localparam logic [7:0] PROT_QUARTER_BASE = 8'hc0;
   localparam logic [7:0] PROT_HALF_BASE = 8'h80;

   // Byte framing
   localparam int PAGE_BYTES = 16;
   localparam int EE_BYTES = 256;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;

   // Internal write cycle
   localparam int CLK_HZ = 20000000;
   localparam int WRITE_TIME_US = 5000;
   localparam int WRITE_CYCLES_DEFAULT = WRITE_TIME_US * (CLK_HZ / 1000000);

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_INDEX,
      PH_WDATA,
      PH_RDATA
   } phase_t;

   // Page load handed from the bus side to the commit logic
   typedef struct packed {
      logic [3:0] page;
      logic [PAGE_BYTES-1:0] mask;
      logic [PAGE_BYTES-1:0][7:0] data;
   } ee_req_t;

endpackage

/* pot_eeprom_serial_slave.sv */
// Two-wire slave for two digital potentiometers and a 256-byte EEPROM.
// Assumes open-drain SDA resolved outside; SCL clocks the bus-facing logic.
// Summary of operation
// - Master sets the write enable latch before any wiper write.
// - Acknowledge a matching potentiometer write address byte.
// - Instruction byte picks wiper and volatile/nonvolatile; acknowledge if valid.
// - Wiper latched on the rising clock edge after the data LSB.
// - Code 01 is 100-tap, 10 is 256-tap; 00 and 11 not acknowledged.
// - Oversized data clamps to the highest tap, never wraps.
// - For the 256-tap wiper the data byte is the tap number.
// - Nonvolatile wiper stores start at zero, the lowest tap.
// - Wiper read starts with a dummy write; write type ignored.
// - Repeated START with read address returns the selected wiper.
// - Top bit of a 100-tap read is undefined; 256-tap all valid.
// - EEPROM address selects the array; read/write from the last bit.
// - Any unprotected EEPROM address byte 00h to FFh is accepted.
// - Byte write: address, data acknowledged, STOP starts internal write.
// - During the internal write all requests ignored, SDA released.
// - Protected EEPROM address gets no acknowledge after the address byte.
// - Page write increments low four address bits, wrapping in the page.
// - More than 16 bytes overwrite earlier ones at wrapped locations.
// - STOP after page loading starts the nonvolatile write.
// - STOP inside a byte or before its acknowledge cancels the write.
// - EEPROM read address begins current, random or sequential reads.
// - Clear write enable latch aborts writes; data byte not acknowledged.
// - Write type one also writes the nonvolatile store; zero only volatile.
// - While busy no address acknowledge; afterwards acknowledges again.
// - Any active protection also refuses wiper writes.
`timescale 1ns/1ns
module pot_eeprom_serial_slave
   import pot_eeprom_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYCLES_DEFAULT
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic i_strap_address_bit,
   input wire logic i_write_enable_latch,
   input wire logic [1:0] i_protect_field,
   output logic o_busy,
   output logic [7:0] o_wiper100,
   output logic [7:0] o_wiper256
);

   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

   // Protected-address decode
   function automatic logic prot_hit(input logic [1:0] prot, input logic [7:0] addr);
      case (prot)
         PROT_NONE: prot_hit = 1'b0;
         PROT_QUARTER: prot_hit = (addr >= PROT_QUARTER_BASE);
         PROT_HALF: prot_hit = (addr >= PROT_HALF_BASE);
         default: prot_hit = 1'b1;
      endcase
   endfunction

   // Wiper clamp per pot
   function automatic logic [7:0] clamp_tap(input logic [1:0] sel, input logic [7:0] d);
      if (sel == POT_CODE_100 && d > POT100_MAX) begin
         clamp_tap = POT100_MAX;
      end else begin
         clamp_tap = d;
      end
   endfunction

   // Core-domain storage, read quasi-statically by the bus side
   logic [7:0] ee_mem [EE_BYTES];
   logic [7:0] wiper_nonvolatile_store [2];
   logic busy;

   ////////////////////////////////////////////////////////////////////////////
   // Bus-side crossings (SCL domain)

   logic rst_l;
   logic busy_l;
   logic wel_l;
   logic strap_l;
   logic [1:0] prot_l;

   level_sync #(.WIDTH(6)) u_sync_link (
      .i_clk(i_scl),
      .i_en(1'b1),
      .i_d({i_rst, busy, i_write_enable_latch, i_strap_address_bit, i_protect_field}),
      .o_q({rst_l, busy_l, wel_l, strap_l, prot_l})
   );

   ////////////////////////////////////////////////////////////////////////////
   // START detection: SDA fell while SCL was high

   logic sda_at_rise;
   logic start_flag;

   always_ff @(posedge i_scl) begin
      sda_at_rise <= i_sda;
   end

   always_ff @(negedge i_scl) begin
      start_flag <= sda_at_rise & ~i_sda;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte engine

   phase_t phase;
   logic [3:0] bit_cnt;
   logic [7:0] rx_sh;
   logic [7:0] tx_sh;
   logic ack_drv;
   logic to_pot;
   logic [1:0] pot_sel;
   logic write_type_bit;
   logic [7:0] ee_ptr;
   logic [7:0] rd_ptr;
   logic ee_armed;
   logic pot_armed;
   logic [7:0] wiper_counter_reg [2];
   ee_req_t page_load;

   logic [7:0] byte_in;
   logic byte_ok;
   logic [7:0] pot_rd;

   assign byte_in = {rx_sh[6:0], i_sda};
   assign pot_rd = (pot_sel == POT_CODE_256) ? wiper_counter_reg[1] : wiper_counter_reg[0];

   always_comb begin
      byte_ok = 1'b0;
      case (phase)
         PH_ADDR: begin
            byte_ok = byte_in[ADDR_TYPE_LSB +: 4] == DEV_TYPE
               && byte_in[ADDR_STRAP_BIT] == strap_l && !busy_l
               && (byte_in[ADDR_SEL_LSB +: 2] == SEL_EEPROM
               || byte_in[ADDR_SEL_LSB +: 2] == SEL_POT);
         end
         PH_INDEX: begin
            if (to_pot) begin
               byte_ok = byte_in[1:0] == POT_CODE_100 || byte_in[1:0] == POT_CODE_256;
            end else begin
               byte_ok = !prot_hit(prot_l, byte_in);
            end
         end
         PH_WDATA: begin
            byte_ok = wel_l && (!to_pot || prot_l == PROT_NONE);
         end
         default: byte_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_scl) begin
      if (rst_l) begin
         phase <= PH_IDLE;
         bit_cnt <= 4'h0;
         rx_sh <= 8'h00;
         tx_sh <= 8'h00;
         ack_drv <= 1'b0;
         to_pot <= 1'b0;
         pot_sel <= POT_CODE_100;
         write_type_bit <= 1'b0;
         ee_ptr <= 8'h00;
         rd_ptr <= 8'h00;
         ee_armed <= 1'b0;
         pot_armed <= 1'b0;
      end else if (start_flag) begin
         // First address bit arrives on this edge
         phase <= PH_ADDR;
         bit_cnt <= 4'h1;
         rx_sh <= {7'h00, i_sda};
         ack_drv <= 1'b0;
         ee_armed <= 1'b0;
         pot_armed <= 1'b0;
      end else if (phase != PH_IDLE) begin
         if (bit_cnt != BIT_ACK) begin
            bit_cnt <= bit_cnt + 4'h1;
            rx_sh <= byte_in;
            tx_sh <= {tx_sh[6:0], 1'b0};
            // Second bit of a new byte disarms
            // The STOP's own clock rise looks like a first bit
            if (phase == PH_WDATA && bit_cnt == 4'h1) begin
               ee_armed <= 1'b0;
            end
            if (bit_cnt == BIT_LAST) begin
               ack_drv <= byte_ok;
            end
         end else begin
            bit_cnt <= 4'h0;
            ack_drv <= 1'b0;
            case (phase)
               PH_ADDR: begin
                  if (ack_drv) begin
                     to_pot <= rx_sh[ADDR_SEL_LSB +: 2] == SEL_POT;
                     if (rx_sh[ADDR_RW_BIT]) begin
                        phase <= PH_RDATA;
                        if (rx_sh[ADDR_SEL_LSB +: 2] == SEL_POT) begin
                           tx_sh <= pot_rd;
                        end else begin
                           tx_sh <= ee_mem[rd_ptr];
                           rd_ptr <= rd_ptr + 8'h01;
                        end
                     end else begin
                        phase <= PH_INDEX;
                     end
                  end else begin
                     phase <= PH_IDLE;
                  end
               end
               PH_INDEX: begin
                  if (ack_drv) begin
                     phase <= PH_WDATA;
                     if (to_pot) begin
                        // Type kept but unused on read
                        pot_sel <= rx_sh[1:0];
                        write_type_bit <= rx_sh[INSTR_WT_BIT];
                     end else begin
                        ee_ptr <= rx_sh;
                        rd_ptr <= rx_sh;
                     end
                  end else begin
                     phase <= PH_IDLE;
                  end
               end
               PH_WDATA: begin
                  if (ack_drv && to_pot) begin
                     pot_armed <= write_type_bit;
                     phase <= PH_IDLE;
                  end else if (ack_drv) begin
                     ee_armed <= 1'b1;
                     ee_ptr <= {ee_ptr[7:4], ee_ptr[3:0] + 4'h1};
                  end else begin
                     phase <= PH_IDLE;
                  end
               end
               PH_RDATA: begin
                  if (!i_sda && !to_pot) begin
                     // Master ack asks for the next byte
                     tx_sh <= ee_mem[rd_ptr];
                     rd_ptr <= rd_ptr + 8'h01;
                  end else begin
                     phase <= PH_IDLE;
                  end
               end
               default: phase <= PH_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page load buffer

   always_ff @(posedge i_scl) begin
      if (rst_l) begin
         page_load.mask <= '0;
      end else if (phase == PH_INDEX && bit_cnt == BIT_ACK && ack_drv && !to_pot) begin
         // Cleared only by an accepted write, so polls never touch a pending load
         page_load.mask <= '0;
      end else if (phase == PH_WDATA && bit_cnt == BIT_ACK && ack_drv && !to_pot) begin
         page_load.data[ee_ptr[3:0]] <= rx_sh;
         page_load.mask[ee_ptr[3:0]] <= 1'b1;
         page_load.page <= ee_ptr[7:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wiper counters

   always_ff @(posedge i_scl) begin
      if (rst_l) begin
         // Recall from nonvolatile store
         wiper_counter_reg[0] <= wiper_nonvolatile_store[0];
         wiper_counter_reg[1] <= wiper_nonvolatile_store[1];
      end else if (phase == PH_WDATA && bit_cnt == BIT_ACK && ack_drv && to_pot) begin
         // Only reached with the latch set
         // Latched on the edge after the LSB
         if (pot_sel == POT_CODE_256) begin
            wiper_counter_reg[1] <= rx_sh;
         end else begin
            wiper_counter_reg[0] <= clamp_tap(pot_sel, rx_sh);
         end
      end
   end

   assign o_wiper100 = wiper_counter_reg[0];
   assign o_wiper256 = wiper_counter_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // SDA drive, updated while SCL is low

   always_ff @(negedge i_scl) begin
      if (rst_l || busy_l) begin
         o_sda_oe <= 1'b0;
      end else if (bit_cnt == BIT_ACK) begin
         o_sda_oe <= ack_drv;
      end else if (phase == PH_RDATA) begin
         // 100-tap top bit reads as stored
         o_sda_oe <= ~tx_sh[7];
      end else begin
         o_sda_oe <= 1'b0;
      end
   end

   // Open drain: only ever pulls low
   assign o_sda_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // STOP detection: SDA rose while SCL was high
   // Core clock is too slow to oversample SCL, so SDA clocks this

   logic stop_tgl;
   logic req_ee;
   logic req_pot;
   logic tgl_s;
   logic tgl_d;
   logic stop_evt;

   // Only an armed write is handed over
   always_ff @(posedge i_sda) begin
      if (rst_l) begin
         stop_tgl <= 1'b0;
      end else if (i_scl && (ee_armed || pot_armed)) begin
         stop_tgl <= ~stop_tgl;
         req_ee <= ee_armed;
         req_pot <= pot_armed;
      end
   end

   // Toggle crosses; request bits are stable by the time it lands
   level_sync #(.WIDTH(1)) u_sync_core (
      .i_clk(i_clk),
      .i_en(i_ce),
      .i_d(stop_tgl),
      .o_q(tgl_s)
   );

   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         tgl_d <= tgl_s;
      end
   end

   assign stop_evt = tgl_s ^ tgl_d;

   ////////////////////////////////////////////////////////////////////////////
   // Internal write cycle

   logic [CNT_W-1:0] busy_cnt;
   logic commit_ee;
   logic commit_pot;
   logic commit_now;

   assign commit_now = busy && busy_cnt == CNT_LAST;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         busy <= 1'b0;
         busy_cnt <= '0;
         commit_ee <= 1'b0;
         commit_pot <= 1'b0;
      end else if (i_ce) begin
         if (!busy && stop_evt) begin
            busy <= 1'b1;
            busy_cnt <= '0;
            commit_ee <= req_ee;
            commit_pot <= req_pot;
         end else if (commit_now) begin
            busy <= 1'b0;
         end else if (busy) begin
            busy_cnt <= busy_cnt + CNT_W'(1);
         end
      end
   end

   assign o_busy = busy;

   // Bus side is frozen while busy, so the load is stable here
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < EE_BYTES; i++) begin
            ee_mem[i] <= EE_ERASED;
         end
      end else if (i_ce && commit_now && commit_ee) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_load.mask[i]) begin
               ee_mem[{page_load.page, 4'(i)}] <= page_load.data[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wiper_nonvolatile_store[0] <= NV_WIPER_RESET;
         wiper_nonvolatile_store[1] <= NV_WIPER_RESET;
      end else if (i_ce && commit_now && commit_pot) begin
         if (pot_sel == POT_CODE_256) begin
            wiper_nonvolatile_store[1] <= wiper_counter_reg[1];
         end else begin
            wiper_nonvolatile_store[0] <= wiper_counter_reg[0];
         end
      end
   end

endmodule

/* pot_eeprom_serial_slave_properties.sv */
// Port-level checker for the two-wire potentiometer / EEPROM slave.
// Assumes core clock and SCL domains, both reset by i_rst active high.
`timescale 1ns/1ns
module pot_eeprom_serial_slave_properties
   import pot_eeprom_pkg::*;
#(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_o,
   input wire logic o_sda_oe,
   input wire logic i_strap_address_bit,
   input wire logic i_write_enable_latch,
   input wire logic [1:0] i_protect_field,
   input wire logic o_busy,
   input wire logic [7:0] o_wiper100,
   input wire logic [7:0] o_wiper256
);
   int busy_len;
   // Run length of busy, frozen while the core is disabled
   always_ff @(posedge i_clk) begin
      if (i_rst || !o_busy) begin
         busy_len <= 0;
      end else if (i_ce) begin
         busy_len <= busy_len + 1;
      end
   end
   // Drive level seen at each SCL rise
   logic oe_at_rise;
   always_ff @(posedge i_scl) begin
      oe_at_rise <= o_sda_oe;
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence s_bus_idle;
      i_scl && i_sda && !o_sda_oe;
   endsequence
   property p_open_drain;
      @(posedge i_clk) disable iff (i_rst) o_sda_o == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("sda driven high");
   property p_clamp100;
      @(posedge i_clk) disable iff (i_rst) o_wiper100 <= POT100_MAX;
   endproperty
   a_clamp100: assert property (p_clamp100)
      else $error("wiper100 above top tap");
   property p_busy_len;
      @(posedge i_clk) disable iff (i_rst)
         $fell(o_busy) |-> busy_len inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]};
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length wrong");
   property p_busy_quiet;
      @(posedge i_clk) disable iff (i_rst) o_busy |-> !o_sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("sda driven while busy");
   property p_busy_from_stop;
      @(posedge i_clk) disable iff (i_rst) $rose(o_busy) |-> s_bus_idle;
   endproperty
   a_busy_from_stop: assert property (p_busy_from_stop)
      else $error("busy began inside a frame");
   property p_busy_wipers;
      @(posedge i_clk) disable iff (i_rst)
         o_busy && $past(o_busy) |-> $stable(o_wiper100) && $stable(o_wiper256);
   endproperty
   a_busy_wipers: assert property (p_busy_wipers)
      else $error("wiper moved while busy");
   property p_prot_wipers;
      @(posedge i_scl) disable iff (i_rst)
         i_protect_field != PROT_NONE |-> $stable(o_wiper100) && $stable(o_wiper256);
   endproperty
   a_prot_wipers: assert property (p_prot_wipers)
      else $error("wiper moved while protected");
   property p_wel_wipers;
      @(posedge i_scl) disable iff (i_rst)
         !i_write_enable_latch |-> $stable(o_wiper100) && $stable(o_wiper256);
   endproperty
   a_wel_wipers: assert property (p_wel_wipers)
      else $error("wiper moved with latch clear");
   property p_oe_scl_high;
      @(negedge i_scl) disable iff (i_rst) o_sda_oe == oe_at_rise;
   endproperty
   a_oe_scl_high: assert property (p_oe_scl_high)
      else $error("sda drive changed with scl high");
endmodule
bind pot_eeprom_serial_slave pot_eeprom_serial_slave_properties #(
   .WRITE_CYCLES(WRITE_CYCLES)
) chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_strap_address_bit(i_strap_address_bit),
   .i_write_enable_latch(i_write_enable_latch), .i_protect_field(i_protect_field),
   .o_busy(o_busy), .o_wiper100(o_wiper100), .o_wiper256(o_wiper256));

/* tb_pot_eeprom_serial_slave.sv */
// Self-checking bench for the two-wire potentiometer / EEPROM slave.
// Assumes the master model clocks SCL unrelated to the 50 ns core clock.
`timescale 1ns/1ns
module tb_pot_eeprom_serial_slave
   import pot_eeprom_pkg::*;
;
   localparam int WCYC = 40;
   localparam logic [6:0] AP = {DEV_TYPE, 1'b1, SEL_POT};
   localparam logic [6:0] AE = {DEV_TYPE, 1'b1, SEL_EEPROM};
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_write_enable_latch = 1'b1;
   logic [1:0] i_protect_field = PROT_NONE;
   logic scl, m_oe, sda, o_sda_o, o_sda_oe, o_busy, a;
   logic [7:0] o_wiper100, o_wiper256, d;
   logic [7:0] exp_mem [16];
   int mismatches = 0;
   int samples_checked = 0;
   always #25 i_clk = !i_clk;
   assign sda = (o_sda_oe ? o_sda_o : 1'b1) & !m_oe;
   two_wire_master_model m (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));
   pot_eeprom_serial_slave #(.WRITE_CYCLES(WCYC)) dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_ce(1'b1), .i_scl(scl), .i_sda(sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
      .i_strap_address_bit(1'b1), .i_write_enable_latch(i_write_enable_latch),
      .i_protect_field(i_protect_field), .o_busy(o_busy), .o_wiper100(o_wiper100),
      .o_wiper256(o_wiper256));
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk_flag(input string what, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic sb(input logic [7:0] v, input logic e);
      m.wr(v, a);
      chk_flag("ack", e, a);
   endtask
   task automatic pot_wr(input logic [1:0] c, input logic wt, input logic [7:0] v,
         input logic e);
      m.start();
      sb({AP, 1'b0}, 1'b1);
      sb({wt, 5'h00, c}, 1'b1);
      sb(v, e);
      m.stop();
   endtask
   task automatic pot_rd(input logic [1:0] c, input logic [7:0] e);
      m.start();
      sb({AP, 1'b0}, 1'b1);
      sb({1'b1, 5'h00, c}, 1'b1);
      m.start();
      sb({AP, 1'b1}, 1'b1);
      m.rd(1'b0, d);
      m.stop();
      chk_byte("wiper read", e, d);
   endtask
   task automatic ee_wr(input logic [7:0] ad, input int n, input logic [7:0] v,
         input logic e);
      m.start();
      sb({AE, 1'b0}, 1'b1);
      sb(ad, 1'b1);
      for (int i = 0; i < n; i++) sb(v + 8'(i), e);
      m.stop();
   endtask
   task automatic ee_rd(input logic [7:0] ad, input int n);
      m.start();
      sb({AE, 1'b0}, 1'b1);
      sb(ad, 1'b1);
      m.start();
      sb({AE, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.rd(i < n - 1, d);
         chk_byte("eeprom", exp_mem[(ad + i) % 16], d);
      end
      m.stop();
   endtask
   // Bounded wait; a poll must be refused while busy and taken after
   task automatic busy_cycle();
      int n;
      n = 0;
      while (o_busy !== 1'b1 && n < 100) begin
         @(negedge i_clk);
         n++;
      end
      chk_flag("busy", 1'b1, o_busy);
      m.start();
      sb({AE, 1'b0}, 1'b0);
      m.stop();
      n = 0;
      while (o_busy !== 1'b0 && n < 200) begin
         @(negedge i_clk);
         n++;
      end
      m.start();
      sb({AE, 1'b0}, 1'b1);
      m.stop();
   endtask
   task automatic quiet();
      logic s;
      s = 1'b0;
      repeat (20) begin
         @(negedge i_clk);
         s |= o_busy;
      end
      chk_flag("busy", 1'b0, s);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      stop_test();
   end
   initial begin
      logic [7:0] lo;
      fork
         m.pulses(4);
         repeat (16) @(posedge i_clk);
      join
      i_rst <= 1'b0;
      // Bus side leaves reset only on SCL edges
      m.pulses(3);
      repeat (4) @(negedge i_clk);
      chk_byte("wiper100", NV_WIPER_RESET, o_wiper100);
      chk_byte("wiper256", NV_WIPER_RESET, o_wiper256);
      pot_wr(POT_CODE_256, 1'b0, 8'h0f, 1'b1);
      quiet();
      chk_byte("wiper256", 8'h0f, o_wiper256);
      pot_wr(POT_CODE_100, 1'b0, 8'hc8, 1'b1);
      chk_byte("wiper100", POT100_MAX, o_wiper100);
      pot_rd(POT_CODE_256, 8'h0f);
      pot_rd(POT_CODE_100, POT100_MAX);
      for (int c = 0; c < 4; c += 3) begin
         m.start();
         sb({AP, 1'b0}, 1'b1);
         sb({6'h00, 2'(c)}, 1'b0);
         m.stop();
      end
      m.start();
      sb({DEV_TYPE, 1'b0, SEL_POT, 1'b0}, 1'b0);
      m.stop();
      pot_wr(POT_CODE_100, 1'b1, 8'h2a, 1'b1);
      busy_cycle();
      chk_byte("wiper100", 8'h2a, o_wiper100);
      @(posedge i_clk);
      i_write_enable_latch <= 1'b0;
      pot_wr(POT_CODE_256, 1'b0, 8'h33, 1'b0);
      chk_byte("wiper256", 8'h0f, o_wiper256);
      ee_wr(8'h05, 1, 8'h5a, 1'b0);
      quiet();
      @(posedge i_clk);
      i_write_enable_latch <= 1'b1;
      ee_wr(8'h05, 1, 8'ha5, 1'b1);
      busy_cycle();
      exp_mem[5] = 8'ha5;
      ee_rd(8'h05, 1);
      ee_wr(8'h3b, 18, 8'h10, 1'b1);
      busy_cycle();
      for (int i = 0; i < 18; i++) exp_mem[(11 + i) % 16] = 8'h10 + 8'(i);
      ee_rd(8'h30, 16);
      m.start();
      sb({AE, 1'b0}, 1'b1);
      sb(8'h50, 1'b1);
      sb(8'h77, 1'b1);
      repeat (4) m.bit_io(1'b0, a);
      m.stop();
      quiet();
      exp_mem[0] = EE_ERASED;
      ee_rd(8'h50, 1);
      for (int p = 1; p < 4; p++) begin
         lo = (p == 1) ? PROT_QUARTER_BASE : (p == 2) ? PROT_HALF_BASE : 8'h00;
         @(posedge i_clk);
         i_protect_field <= 2'(p);
         m.start();
         sb({AE, 1'b0}, 1'b1);
         sb(lo, 1'b0);
         m.stop();
         if (p < 3) begin
            m.start();
            sb({AE, 1'b0}, 1'b1);
            sb(lo - 8'h01, 1'b1);
            m.stop();
         end
         pot_wr(POT_CODE_256, 1'b0, 8'h44, 1'b0);
         chk_byte("wiper256", 8'h0f, o_wiper256);
      end
      stop_test();
   end
endmodule

/* two_wire_master_model.sv */
// Two-wire bus master model: drives SCL and pulls SDA low.
// Assumes a pull-up on SDA outside; SCL runs at 80 ns inside frames and in free pulses.
`timescale 1ns/1ns
module two_wire_master_model (
   output logic o_scl,
   output logic o_sda_oe,
   input wire logic i_sda
);
   localparam int Q = 20;
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // Free pulses only while the slave is in reset or leaving it
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++) begin
         #Q o_scl = 1'b0;
         #(2*Q) o_scl = 1'b1;
         #Q;
      end
   endtask
   task automatic bit_io(input logic b, output logic r);
      o_sda_oe = !b;
      #Q o_scl = 1'b1;
      #Q r = i_sda;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   task automatic start();
      // After a STOP, SCL must rise again with SDA high
      o_scl = 1'b0;
      o_sda_oe = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b1;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   task automatic stop();
      o_sda_oe = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b0;
      #Q;
   endtask
   task automatic wr(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd(input logic more, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(!more, r);
   endtask
endmodule
